// ===== logic/cisr_cfg.svh
// Constants for the command input source router
`ifndef CISR_CFG_SVH
`define CISR_CFG_SVH

// Selector codes shared by the dedicated source selectors
`define CISR_CODE_NONE 4'h0
`define CISR_CODE_JOG 4'h1
`define CISR_CODE_ENC 4'h2
`define CISR_CODE_T2 4'h3
`define CISR_CODE_T4 4'h4
`define CISR_CODE_T1 4'h5
`define CISR_CODE_T6 4'h6
`define CISR_CODE_OPT 4'h7

// Terminal slots in the per-terminal arrays
`define CISR_IDX_T1 2'h0
`define CISR_IDX_T2 2'h1
`define CISR_IDX_T4 2'h2
`define CISR_IDX_T6 2'h3

// Pulse input function values that enable the jog pulse train
`define CISR_PFN_A 8'h01
`define CISR_PFN_B 8'h0b
`define CISR_PFN_C 8'h15
`define CISR_PFN_D 8'h64

// General assignment code meaning frequency command
`define CISR_ASSIGN_FREQ 4'h0

// Register byte offsets
`define CISR_OFS_CTRL 8'h00
`define CISR_OFS_SEL 8'h04
`define CISR_OFS_ASSIGN 8'h08
`define CISR_OFS_RANGE 8'h0c
`define CISR_OFS_DMIN 8'h10
`define CISR_OFS_DMAX 8'h14
`define CISR_OFS_STAT 8'h40
`define CISR_OFS_DIAM 8'h44
`define CISR_OFS_LSC 8'h48
`define CISR_OFS_ALS 8'h4c
`define CISR_OFS_FRQ 8'h50
// Calibration block: 0x20 + 8*terminal, min at +0, max at +4
`define CISR_CAL_HI 3'h1

// Field positions
`define CISR_CTRL_MODE 1:0
`define CISR_CTRL_WDIR 2
`define CISR_CTRL_CLR 3
`define CISR_CTRL_PFN 15:8
`define CISR_SEL_LSC 3:0
`define CISR_SEL_ALS 7:4
`define CISR_SEL_DFB 11:8
`define CISR_SEL_DTS 15:12
`define CISR_SEL_TAP 19:16
`define CISR_SEL_TCM 23:20
`define CISR_SEL_CMP 27:24
`define CISR_ASG_T1 3:0
`define CISR_ASG_T4 7:4
`define CISR_ASG_T6 11:8
`define CISR_STAT_FVLD 16
`define CISR_STAT_JOG 17
`define CISR_STAT_STALE 23:20

// Reset values and scaling
`define CISR_CAL_MIN_RST 16'h0000
`define CISR_CAL_MAX_RST 16'h0fff
`define CISR_DMIN_RST 16'h0000
`define CISR_DMAX_RST 16'hffff
`define CISR_DIAM_RST 16'h0000
`define CISR_FS 16'h2710

`endif

// ===== logic/cisr_diam.sv
// Stored winding diameter with clear to minimum or maximum
`timescale 1ns/100ps
`include "cisr_cfg.svh"
module cisr_diam (
   input wire logic mclk,
   input wire logic srst,
   input wire logic clear,
   input wire logic wind_direction_sel,
   input wire cisr_pkg::cisr_word_t diam_min,
   input wire cisr_pkg::cisr_word_t diam_max,
   input wire logic update_valid,
   input wire cisr_pkg::cisr_word_t update_value,
   output cisr_pkg::cisr_word_t diameter
);
   import cisr_pkg::*;

   cisr_dia_s st_q;
   cisr_dia_s st_d;

   // Clear beats a calculated update landing in the same cycle
   always_comb begin
      st_d = st_q;
      if (clear) begin
         st_d.diam = wind_direction_sel ? diam_max : diam_min;
      end else if (update_valid) begin
         st_d.diam = update_value;
      end
   end

   // State register
   always_ff @(posedge mclk) begin
      if (srst) begin
         st_q.diam <= `CISR_DIAM_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign diameter = st_q.diam;

   a_diam_clear: assert property (@(posedge mclk) disable iff (srst)
      clear |=> (diameter == ($past(wind_direction_sel) ? $past(diam_max) : $past(diam_min))))
      else $error("cleared diameter not loaded from limit for wind direction");
   a_diam_hold: assert property (@(posedge mclk) disable iff (srst)
      (!clear && !update_valid) |=> $stable(diameter))
      else $error("diameter moved without clear or update");
endmodule

// ===== logic/cisr_pkg.sv
// Types for the command input source router
package cisr_pkg;
`include "cisr_cfg.svh"

   typedef logic [15:0] cisr_word_t;
   typedef logic [31:0] cisr_bus_t;

   typedef enum logic [1:0] {
      CISR_MODE_SPEED = 2'b00,
      CISR_MODE_TQ_SENSORLESS = 2'b01,
      CISR_MODE_TQ_SENSOR = 2'b10
   } cisr_mode_e;

   typedef enum logic [3:0] {
      CISR_FN_NONE = 4'h0,
      CISR_FN_DFB = 4'h1,
      CISR_FN_ALS = 4'h2,
      CISR_FN_TCM = 4'h3,
      CISR_FN_LSC = 4'h4,
      CISR_FN_TAP = 4'h5,
      CISR_FN_DTS = 4'h6,
      CISR_FN_CMP = 4'h7,
      CISR_FN_FRQ = 4'h8
   } cisr_fn_e;

   typedef struct packed {
      logic [15:0] value;
   } cisr_scl_s;

   typedef struct packed {
      logic [15:0] diam;
   } cisr_dia_s;

   typedef struct packed {
      logic wreq;
      logic [31:0] rdata;
      logic [1:0] mode;
      logic wdir;
      logic diam_clr;
      logic [7:0] pfn;
      logic [27:0] sel;
      logic [11:0] asg;
      logic [3:0] half;
      logic [3:0] stale;
      logic [3:0] sw_prev;
      logic [15:0] dmin;
      logic [15:0] dmax;
      logic [7:0][15:0] cal;
      logic [3:0][3:0] owner;
      logic [2:0] fsrc;
      logic [15:0] dfb;
      logic [15:0] lsc;
      logic [15:0] als;
      logic [15:0] tap;
      logic [15:0] dts;
      logic [15:0] tcm;
      logic [15:0] cmp;
      logic [15:0] frq;
      logic fvld;
      logic jog_ok;
   } cisr_rt_s;
endpackage

// ===== logic/cisr_router.sv
// Command input source router: terminal ownership, routing and registers
// Function
// - Diameter clear loads minimum when winding, maximum when unwinding.
// - Frequency command never taken from the line speed command terminal.
// - Selector zero: line speed shares the frequency terminal; calibrate both alike.
// - Analog codes: 5 terminal 1, 3 terminal 2, 4 terminal 4, 6 terminal 6.
// - Line speed codes: 1 jog pulses, 7 option pulses, 2 encoder pulses.
// - Jog pulse selection works only with pulse function 1, 11, 21 or 100.
// - Dedicated selectors override general terminal function assignments.
// - A shared terminal serves only its highest priority function.
// - Priority: dancer, actual speed, tension, speed, taper, dancer tension, compensation.
// - Torque modes with actual selector zero use the ramped line speed.
// - Dancer tension selector inactive in either torque control mode.
// - Selector zero in sensorless torque: line speed via frequency path.
// - Analog inputs scaled between calibration points in chosen range.
// - Dancer feedback comes from analog terminal 1, 2, 4 or 6.
`timescale 1ns/100ps
`include "cisr_cfg.svh"
module cisr_router #(
   parameter int RAW_W = 12
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire cisr_pkg::cisr_bus_t avs_writedata,
   output cisr_pkg::cisr_bus_t avs_readdata,
   output logic avs_waitrequest,
   input wire logic [RAW_W-1:0] adc_raw_t1,
   input wire logic [RAW_W-1:0] adc_raw_t2,
   input wire logic [RAW_W-1:0] adc_raw_t4,
   input wire logic [RAW_W-1:0] adc_raw_t6,
   input wire logic [3:0] range_current_sw,
   input wire cisr_pkg::cisr_word_t jog_pulse_terminal,
   input wire cisr_pkg::cisr_word_t option_pulse_value,
   input wire cisr_pkg::cisr_word_t encoder_pulse_value,
   input wire cisr_pkg::cisr_word_t ramped_line_speed,
   input wire logic diam_update_valid,
   input wire cisr_pkg::cisr_word_t diam_update_value,
   output cisr_pkg::cisr_word_t dancer_feedback,
   output cisr_pkg::cisr_word_t line_speed_cmd,
   output cisr_pkg::cisr_word_t actual_line_speed,
   output cisr_pkg::cisr_word_t taper_value,
   output cisr_pkg::cisr_word_t dancer_tension_value,
   output cisr_pkg::cisr_word_t tension_cmd_value,
   output cisr_pkg::cisr_word_t line_speed_comp,
   output cisr_pkg::cisr_word_t freq_cmd,
   output logic freq_cmd_valid,
   output cisr_pkg::cisr_word_t winding_diameter
);
   import cisr_pkg::*;

   cisr_rt_s st_q;
   cisr_rt_s st_d;
   logic [3:0][15:0] term_val;
   logic [3:0][RAW_W-1:0] raw_arr;
   logic [3:0] sel_lsc;
   logic [3:0] sel_als;
   logic [3:0] sel_dfb;
   logic [3:0] sel_dts;
   logic [3:0] sel_tap;
   logic [3:0] sel_tcm;
   logic [3:0] sel_cmp;
   logic torque;
   logic jog_ok;

   // Selector code to terminal slot, top bit flags an analog code
   function automatic logic [2:0] code_idx(input logic [3:0] c);
      logic [2:0] r;
      r = 3'h0;
      case (c)
         `CISR_CODE_T1: r = {1'b1, `CISR_IDX_T1};
         `CISR_CODE_T2: r = {1'b1, `CISR_IDX_T2};
         `CISR_CODE_T4: r = {1'b1, `CISR_IDX_T4};
         `CISR_CODE_T6: r = {1'b1, `CISR_IDX_T6};
         default: r = 3'h0;
      endcase
      return r;
   endfunction

   // Highest priority dedicated function naming terminal code c
   function automatic cisr_fn_e owner_of(input logic [3:0] c, input logic [27:0] s,
                                         input logic tq);
      cisr_fn_e f;
      f = CISR_FN_NONE;
      if (s[`CISR_SEL_DFB] == c) begin
         f = CISR_FN_DFB;
      end else if (s[`CISR_SEL_ALS] == c) begin
         f = CISR_FN_ALS;
      end else if (s[`CISR_SEL_TCM] == c) begin
         f = CISR_FN_TCM;
      end else if (s[`CISR_SEL_LSC] == c) begin
         f = CISR_FN_LSC;
      end else if (s[`CISR_SEL_TAP] == c) begin
         f = CISR_FN_TAP;
      end else if (s[`CISR_SEL_DTS] == c && !tq) begin
         f = CISR_FN_DTS;
      end else if (s[`CISR_SEL_CMP] == c) begin
         f = CISR_FN_CMP;
      end
      return f;
   endfunction

   // Value of the terminal a selector names, only if that function owns it
   function automatic logic [15:0] route(input cisr_fn_e f, input logic [3:0] s,
                                         input logic [3:0][3:0] own,
                                         input logic [3:0][15:0] tv);
      logic [2:0] ix;
      logic [15:0] v;
      ix = code_idx(s);
      v = 16'h0000;
      if (ix[2] && own[ix[1:0]] == f) begin
         v = tv[ix[1:0]];
      end
      return v;
   endfunction

   assign raw_arr = {adc_raw_t6, adc_raw_t4, adc_raw_t2, adc_raw_t1};
   assign sel_lsc = st_q.sel[`CISR_SEL_LSC];
   assign sel_als = st_q.sel[`CISR_SEL_ALS];
   assign sel_dfb = st_q.sel[`CISR_SEL_DFB];
   assign sel_dts = st_q.sel[`CISR_SEL_DTS];
   assign sel_tap = st_q.sel[`CISR_SEL_TAP];
   assign sel_tcm = st_q.sel[`CISR_SEL_TCM];
   assign sel_cmp = st_q.sel[`CISR_SEL_CMP];
   assign torque = (cisr_mode_e'(st_q.mode) != CISR_MODE_SPEED);
   // Jog pulses only mean line speed under the matching pulse function
   assign jog_ok = (st_q.pfn == `CISR_PFN_A) || (st_q.pfn == `CISR_PFN_B) ||
                   (st_q.pfn == `CISR_PFN_C) || (st_q.pfn == `CISR_PFN_D);

   // One scaler per analog terminal
   for (genvar g = 0; g < 4; g++) begin : g_scl
      cisr_scaler #(.RAW_W(RAW_W)) u_scl (
         .mclk(mclk),
         .srst(srst),
         .raw(raw_arr[g]),
         .half_scale(st_q.half[g]),
         .current_mode(range_current_sw[g]),
         .cal_min(st_q.cal[2*g]),
         .cal_max(st_q.cal[2*g+1]),
         .value(term_val[g])
      );
   end

   // Diameter store
   cisr_diam u_diam (
      .mclk(mclk),
      .srst(srst),
      .clear(st_q.diam_clr),
      .wind_direction_sel(st_q.wdir),
      .diam_min(st_q.dmin),
      .diam_max(st_q.dmax),
      .update_valid(diam_update_valid),
      .update_value(diam_update_value),
      .diameter(winding_diameter)
   );

   // Bus slave, ownership and routing; all outputs but winding_diameter land in st_q one edge later
   always_comb begin
      logic [31:0] rd;
      logic [3:0][3:0] own;
      rd = 32'h0;
      own = '0;
      st_d = st_q;
      st_d.diam_clr = 1'b0;
      // Ownership is recomputed every cycle from live selectors
      own[`CISR_IDX_T1] = owner_of(`CISR_CODE_T1, st_q.sel, torque);
      own[`CISR_IDX_T2] = owner_of(`CISR_CODE_T2, st_q.sel, torque);
      own[`CISR_IDX_T4] = owner_of(`CISR_CODE_T4, st_q.sel, torque);
      own[`CISR_IDX_T6] = owner_of(`CISR_CODE_T6, st_q.sel, torque);
      st_d.owner = own;
      // Frequency command from terminal 2 if free, else first free terminal set to frequency: 4, 1, then 6
      st_d.fsrc = 3'h0;
      if (own[`CISR_IDX_T2] == CISR_FN_NONE) begin
         st_d.fsrc = {1'b1, `CISR_IDX_T2};
      end else if (own[`CISR_IDX_T4] == CISR_FN_NONE &&
                   st_q.asg[`CISR_ASG_T4] == `CISR_ASSIGN_FREQ) begin
         st_d.fsrc = {1'b1, `CISR_IDX_T4};
      end else if (own[`CISR_IDX_T1] == CISR_FN_NONE &&
                   st_q.asg[`CISR_ASG_T1] == `CISR_ASSIGN_FREQ) begin
         st_d.fsrc = {1'b1, `CISR_IDX_T1};
      end else if (own[`CISR_IDX_T6] == CISR_FN_NONE &&
                   st_q.asg[`CISR_ASG_T6] == `CISR_ASSIGN_FREQ) begin
         st_d.fsrc = {1'b1, `CISR_IDX_T6};
      end
      st_d.fvld = st_d.fsrc[2];
      st_d.frq = st_d.fsrc[2] ? term_val[st_d.fsrc[1:0]] : 16'h0000;
      st_d.jog_ok = jog_ok;
      // Dedicated functions
      st_d.dfb = route(CISR_FN_DFB, sel_dfb, own, term_val);
      st_d.tcm = route(CISR_FN_TCM, sel_tcm, own, term_val);
      st_d.tap = route(CISR_FN_TAP, sel_tap, own, term_val);
      st_d.dts = route(CISR_FN_DTS, sel_dts, own, term_val);
      st_d.cmp = route(CISR_FN_CMP, sel_cmp, own, term_val);
      // Line speed command: shared frequency path, pulse sources or analog
      case (sel_lsc)
         `CISR_CODE_NONE: st_d.lsc = st_d.frq;
         `CISR_CODE_JOG: st_d.lsc = jog_ok ? jog_pulse_terminal : 16'h0000;
         `CISR_CODE_OPT: st_d.lsc = option_pulse_value;
         `CISR_CODE_ENC: st_d.lsc = encoder_pulse_value;
         default: st_d.lsc = route(CISR_FN_LSC, sel_lsc, own, term_val);
      endcase
      // Actual line speed falls back to the ramped command under torque control
      if (sel_als == `CISR_CODE_NONE) begin
         st_d.als = torque ? ramped_line_speed : 16'h0000;
      end else begin
         st_d.als = route(CISR_FN_ALS, sel_als, own, term_val);
      end
      // Range switch movement marks the terminal as needing calibration
      st_d.sw_prev = range_current_sw;
      for (int t = 0; t < 4; t++) begin
         if (avs_write && !st_q.wreq && avs_address[7:5] == `CISR_CAL_HI &&
             avs_address[4:3] == 2'(t) && avs_address[2]) begin
            st_d.stale[t] = 1'b0;
         end
      end
      // Read mux
      case (avs_address)
         `CISR_OFS_CTRL: rd = {16'h0, st_q.pfn, 4'h0, 1'b0, st_q.wdir, st_q.mode};
         `CISR_OFS_SEL: rd = {4'h0, st_q.sel};
         `CISR_OFS_ASSIGN: rd = {20'h0, st_q.asg};
         `CISR_OFS_RANGE: rd = {28'h0, st_q.half};
         `CISR_OFS_DMIN: rd = {16'h0, st_q.dmin};
         `CISR_OFS_DMAX: rd = {16'h0, st_q.dmax};
         `CISR_OFS_STAT: rd = {8'h0, st_q.stale, 2'h0, st_q.jog_ok, st_q.fvld, st_q.owner};
         `CISR_OFS_DIAM: rd = {16'h0, winding_diameter};
         `CISR_OFS_LSC: rd = {16'h0, st_q.lsc};
         `CISR_OFS_ALS: rd = {16'h0, st_q.als};
         `CISR_OFS_FRQ: rd = {16'h0, st_q.frq};
         default: begin
            if (avs_address[7:5] == `CISR_CAL_HI && avs_address[1:0] == 2'h0) begin
               rd = {16'h0, st_q.cal[avs_address[4:2]]};
            end
         end
      endcase
      // Two-cycle handshake: waitrequest drops for one cycle per access
      if ((avs_read || avs_write) && st_q.wreq) begin
         st_d.wreq = 1'b0;
         st_d.rdata = rd;
      end else begin
         st_d.wreq = 1'b1;
      end
      // Writes take effect at the edge where waitrequest is seen low
      if (avs_write && !st_q.wreq) begin
         case (avs_address)
            `CISR_OFS_CTRL: begin
               st_d.mode = avs_writedata[`CISR_CTRL_MODE];
               st_d.wdir = avs_writedata[`CISR_CTRL_WDIR];
               st_d.diam_clr = avs_writedata[`CISR_CTRL_CLR];
               st_d.pfn = avs_writedata[`CISR_CTRL_PFN];
            end
            `CISR_OFS_SEL: st_d.sel = avs_writedata[27:0];
            `CISR_OFS_ASSIGN: st_d.asg = avs_writedata[11:0];
            `CISR_OFS_RANGE: begin
               st_d.half = avs_writedata[3:0];
            end
            `CISR_OFS_DMIN: st_d.dmin = avs_writedata[15:0];
            `CISR_OFS_DMAX: st_d.dmax = avs_writedata[15:0];
            default: begin
               if (avs_address[7:5] == `CISR_CAL_HI && avs_address[1:0] == 2'h0) begin
                  st_d.cal[avs_address[4:2]] = avs_writedata[15:0];
               end
            end
         endcase
      end
      // Set wins over the calibration clear in the same cycle
      for (int t = 0; t < 4; t++) begin
         if (range_current_sw[t] != st_q.sw_prev[t] ||
             (avs_write && !st_q.wreq && avs_address == `CISR_OFS_RANGE &&
              avs_writedata[t] != st_q.half[t])) begin
            st_d.stale[t] = 1'b1;
         end
      end
   end

   // State register
   always_ff @(posedge mclk) begin
      if (srst) begin
         st_q <= '0;
         st_q.wreq <= 1'b1;
         st_q.dmin <= `CISR_DMIN_RST;
         st_q.dmax <= `CISR_DMAX_RST;
         for (int i = 0; i < 8; i++) begin
            st_q.cal[i] <= (i % 2 == 1) ? `CISR_CAL_MAX_RST : `CISR_CAL_MIN_RST;
         end
      end else begin
         st_q <= st_d;
      end
   end

   assign avs_readdata = st_q.rdata;
   assign avs_waitrequest = st_q.wreq;
   assign dancer_feedback = st_q.dfb;
   assign line_speed_cmd = st_q.lsc;
   assign actual_line_speed = st_q.als;
   assign taper_value = st_q.tap;
   assign dancer_tension_value = st_q.dts;
   assign tension_cmd_value = st_q.tcm;
   assign line_speed_comp = st_q.cmp;
   assign freq_cmd = st_q.frq;
   assign freq_cmd_valid = st_q.fvld;

   sequence s_req_wait;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_answer;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence

   a_bus_answer: assert property (@(posedge mclk) disable iff (srst)
      s_req_wait |=> s_answer)
      else $error("bus access not answered in one wait cycle");
   a_freq_not_lsc: assert property (@(posedge mclk) disable iff (srst)
      // Source was chosen from last cycle's selectors, so compare against those
      st_q.fsrc[2] |-> (code_idx($past(sel_lsc)) != st_q.fsrc))
      else $error("frequency command taken from line speed terminal");
   a_shared_path: assert property (@(posedge mclk) disable iff (srst)
      (sel_lsc == `CISR_CODE_NONE) |=> (line_speed_cmd == freq_cmd))
      else $error("line speed not on frequency path with selector zero");
   a_dancer_map: assert property (@(posedge mclk) disable iff (srst)
      (sel_dfb == `CISR_CODE_T2) |=> (dancer_feedback == $past(term_val[`CISR_IDX_T2])))
      else $error("dancer feedback not from terminal 2");
   a_jog_gate: assert property (@(posedge mclk) disable iff (srst)
      (sel_lsc == `CISR_CODE_JOG) |=>
      (line_speed_cmd == ($past(jog_ok) ? $past(jog_pulse_terminal) : 16'h0000)))
      else $error("jog pulse selection not gated by pulse function");
   a_enc_route: assert property (@(posedge mclk) disable iff (srst)
      (sel_lsc == `CISR_CODE_ENC) |=> (line_speed_cmd == $past(encoder_pulse_value)))
      else $error("encoder pulse not routed to line speed");
   a_override_asg: assert property (@(posedge mclk) disable iff (srst)
      (sel_dfb == `CISR_CODE_T1) |=> (st_q.owner[`CISR_IDX_T1] == CISR_FN_DFB))
      else $error("terminal 1 not owned by dancer feedback");
   a_prio_lower: assert property (@(posedge mclk) disable iff (srst)
      (sel_als == sel_dfb && code_idx(sel_als) != 3'h0 && !$changed(st_q.sel))
      |=> (actual_line_speed == 16'h0000))
      else $error("lower priority function served on shared terminal");
   a_torque_als: assert property (@(posedge mclk) disable iff (srst)
      (torque && sel_als == `CISR_CODE_NONE) |=> (actual_line_speed == $past(ramped_line_speed)))
      else $error("torque mode actual line speed not ramped command");
   a_dts_off: assert property (@(posedge mclk) disable iff (srst)
      torque |=> (dancer_tension_value == 16'h0000))
      else $error("dancer tension routed during torque control");
endmodule

// ===== logic/cisr_scaler.sv
// Calibrated scaling of one analog input terminal
`timescale 1ns/100ps
`include "cisr_cfg.svh"
module cisr_scaler #(
   parameter int RAW_W = 12
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic [RAW_W-1:0] raw,
   input wire logic half_scale,
   input wire logic current_mode,
   input wire cisr_pkg::cisr_word_t cal_min,
   input wire cisr_pkg::cisr_word_t cal_max,
   output cisr_pkg::cisr_word_t value
);
   import cisr_pkg::*;

   cisr_scl_s st_q;
   cisr_scl_s st_d;
   logic [15:0] x;
   logic [31:0] num;
   logic [31:0] quo;

   // Range pick, clamp to calibration points, then linear map to full scale
   always_comb begin
      st_d = st_q;
      x = 16'(raw);
      num = 32'h0;
      quo = 32'h0;
      if (half_scale && !current_mode) begin
         x = 16'({raw, 1'b0}); // 0 to 5 V uses only half the converter span
      end
      if (cal_max <= cal_min || x <= cal_min) begin
         st_d.value = 16'h0000;
      end else if (x >= cal_max) begin
         st_d.value = `CISR_FS;
      end else begin
         // Divider is wide but keeps the mapping exact between the two points
         num = 32'(x - cal_min) * 32'(`CISR_FS);
         quo = num / 32'(cal_max - cal_min);
         st_d.value = quo[15:0];
      end
   end

   // Output register
   always_ff @(posedge mclk) begin
      if (srst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign value = st_q.value;

   a_scale_floor: assert property (@(posedge mclk) disable iff (srst)
      (x <= cal_min) |=> (value == 16'h0000))
      else $error("scaled value not zero at or below calibrated minimum");
   a_scale_top: assert property (@(posedge mclk) disable iff (srst)
      (cal_max > cal_min && x >= cal_max) |=> (value == `CISR_FS))
      else $error("scaled value not full scale at calibrated maximum");
endmodule

// ===== verif/cisr_src_model.sv
// Far-side sources: analog terminals and pulse-rate inputs
`timescale 1ns/100ps
module cisr_src_model (
   input wire logic mclk,
   input wire logic [1:0] hot,
   output logic [11:0] raw_t1,
   output logic [11:0] raw_t2,
   output logic [11:0] raw_t4,
   output logic [11:0] raw_t6,
   output logic [15:0] jog_v,
   output logic [15:0] opt_v,
   output logic [15:0] enc_v,
   output logic [15:0] ramp_v
);
   // One terminal at full scale, others at zero, so a wrong route shows
   always_ff @(posedge mclk) begin
      raw_t1 <= (hot == 2'h0) ? 12'hfff : 12'h000;
      raw_t2 <= (hot == 2'h1) ? 12'hfff : 12'h000;
      raw_t4 <= (hot == 2'h2) ? 12'hfff : 12'h000;
      raw_t6 <= (hot == 2'h3) ? 12'hfff : 12'h000;
   end
   // Distinct pulse rates tell the sources apart
   assign jog_v = 16'h0111;
   assign opt_v = 16'h0222;
   assign enc_v = 16'h0333;
   assign ramp_v = 16'h0444;
endmodule

// ===== verif/tb_top.sv
// Self-checking bench for the command input source router
`timescale 1ns/100ps
module tb_top;
   import cisr_pkg::*;
   logic mclk = 0, srst = 1, rd = 0, wr = 0, wtq;
   logic [7:0] adr = 8'h00;
   logic [31:0] wd = 32'h0, rdq, rdat;
   logic [1:0] hot = 2'h0;
   logic [11:0] r1, r2, r4, r6;
   logic [15:0] jv, ov, ev, rv, dfb, lsc, als, dts, frq, dia, tap, tcm, cmp;
   logic fvld;
   logic [3:0] csw = 4'h0;
   int n_mismatch = 0, checks_done = 0;
   always #50 mclk = ~mclk;
   cisr_src_model src (.mclk(mclk), .hot(hot), .raw_t1(r1), .raw_t2(r2), .raw_t4(r4),
      .raw_t6(r6), .jog_v(jv), .opt_v(ov), .enc_v(ev), .ramp_v(rv));
   cisr_router dut (.mclk(mclk), .srst(srst), .avs_address(adr), .avs_read(rd),
      .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdq), .avs_waitrequest(wtq),
      .adc_raw_t1(r1), .adc_raw_t2(r2), .adc_raw_t4(r4), .adc_raw_t6(r6),
      .range_current_sw(csw), .jog_pulse_terminal(jv), .option_pulse_value(ov),
      .encoder_pulse_value(ev), .ramped_line_speed(rv), .diam_update_valid(1'b0),
      .diam_update_value(16'h0000), .dancer_feedback(dfb), .line_speed_cmd(lsc),
      .actual_line_speed(als), .taper_value(tap), .dancer_tension_value(dts),
      .tension_cmd_value(tcm), .line_speed_comp(cmp), .freq_cmd(frq), .freq_cmd_valid(fvld),
      .winding_diameter(dia));
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Request is held until waitrequest is sampled low, then released
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge mclk);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      i = 0;
      do begin
         @(posedge mclk);
         i++;
      end while (wtq !== 1'b0 && i < 50);
      if (i >= 50) begin
         n_mismatch++;
         wrap_up();
      end
      rdat = rdq;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic cfg(input logic [1:0] h, input logic [31:0] sel);
      hot <= h;
      bus(1'b1, 8'h04, sel);
      repeat (4) @(posedge mclk);
   endtask
   task automatic t_codes;
      logic [3:0] cd [4] = '{4'h5, 4'h3, 4'h4, 4'h6};
      for (int k = 0; k < 4; k++) begin
         cfg(k[1:0], {20'h0, cd[k], 8'h00});
         chk("dancer", dfb, 32'h2710);
      end
   endtask
   task automatic t_prio;
      cfg(2'h1, 32'h333);
      chk("dancer", dfb, 32'h2710);
      chk("actual", als, 32'h0);
      chk("line", lsc, 32'h0);
      cfg(2'h1, 32'h3);
      chk("line", lsc, 32'h2710);
      chk("freq", frq, 32'h0);
      chk("freq valid", {31'h0, fvld}, 32'h1);
      cfg(2'h1, 32'h0030_0003);
      chk("tension cmd", tcm, 32'h2710);
      chk("line", lsc, 32'h0);
      cfg(2'h1, 32'h0303_3000);
      chk("taper", tap, 32'h2710);
      chk("dancer tension", dts, 32'h0);
      chk("comp", cmp, 32'h0);
      cfg(2'h1, 32'h0300_0000);
      chk("comp", cmp, 32'h2710);
      // Every terminal owned: actual speed on terminal 2, no frequency source left
      cfg(2'h1, 32'h0046_0530);
      chk("actual", als, 32'h2710);
      chk("freq valid", {31'h0, fvld}, 32'h0);
   endtask
   task automatic t_pulse;
      logic [7:0] pf [5] = '{8'h01, 8'h0b, 8'h15, 8'h64, 8'h02};
      for (int k = 0; k < 5; k++) begin
         bus(1'b1, 8'h00, {16'h0, pf[k], 8'h00});
         cfg(2'h0, 32'h1);
         chk("jog", lsc, (k < 4) ? 32'h0111 : 32'h0);
      end
      cfg(2'h0, 32'h7);
      chk("option", lsc, 32'h0222);
      cfg(2'h0, 32'h2);
      chk("encoder", lsc, 32'h0333);
   endtask
   task automatic t_torque;
      for (int m = 1; m < 3; m++) begin
         bus(1'b1, 8'h00, m);
         // Terminal 4 hot, so a dancer tension route would show
         cfg(2'h2, 32'h4000);
         chk("tension", dts, 32'h0);
         chk("actual", als, 32'h0444);
      end
      bus(1'b1, 8'h00, 32'h1);
      cfg(2'h1, 32'h4000);
      chk("line", lsc, 32'h2710);
   endtask
   task automatic t_diam;
      bus(1'b1, 8'h10, 32'h0123);
      bus(1'b1, 8'h14, 32'h0abc);
      bus(1'b1, 8'h00, 32'h8);
      repeat (3) @(posedge mclk);
      chk("diam", dia, 32'h0123);
      bus(1'b1, 8'h00, 32'hc);
      repeat (3) @(posedge mclk);
      chk("diam", dia, 32'h0abc);
      bus(1'b0, 8'h10, 32'h0);
      chk("dmin", rdat, 32'h0123);
      bus(1'b0, 8'h80, 32'h0);
      chk("unmapped", rdat, 32'h0);
      // Range change flags terminal 2 until its calibration is redone
      bus(1'b1, 8'h0c, 32'h2);
      bus(1'b0, 8'h40, 32'h0);
      chk("stale", rdat & 32'h00f00000, 32'h00200000);
      bus(1'b1, 8'h2c, 32'h0fff);
      csw <= 4'h4;
      bus(1'b0, 8'h40, 32'h0);
      chk("stale", rdat & 32'h00f00000, 32'h00400000);
   endtask
   // Main sequence: reset, then each scenario in turn
   initial begin
      repeat (6) @(posedge mclk);
      srst <= 1'b0;
      t_codes();
      t_prio();
      t_pulse();
      t_torque();
      t_diam();
      wrap_up();
   end
endmodule
